/* common/rbie_consts.svh */
// Overview of operation
// - reset sets the reset-irq-enable field to one and clears all other status fields.
// - after reset, invalidate only the reset vector cache line, then fetch there.
// - general register zero of the normal set always reads zero.
// - break entry on a break instruction or a debug hardware break request.
// - break entry copies status to break-status and clears global irq enable.
// - break entry writes into general register thirty the following instruction address for a break instruction, the current one for a debug break.
// - break entry clears the user-mode bit when translation or protection exists.
// - break entry sets the exception-active bit when translation exists.
// - break entry copies current regset to previous, then selects regset zero.
// - break entry finally redirects execution to the break vector.
// - nonmaskable interrupts ignore global enable and are taken during a break.
// - break return reloads status from break-status and resumes at register thirty.
// - an external interrupt jumps directly to the supplied handler address.
// - a maskable external interrupt needs requested level above the current level.
// - nonmaskable requests ignore both requested and current interrupt levels.
// - with shadow sets, an external interrupt selects the requested register set.
// - external interrupts clear global enable unless the auto-nest flag is one.
// - internal interrupt fires when global enable, a request and its enable are set.
// - an internal interrupt clears global irq enable on entry.
// - the pending register shows, bit for bit, which requests are pending and have their enable bit set.
`ifndef RBIE_CONSTS_SVH
`define RBIE_CONSTS_SVH

`define RBIE_OFF_STATUS  8'h00
`define RBIE_OFF_BSTATUS 8'h04
`define RBIE_OFF_IENABLE 8'h08
`define RBIE_OFF_IPEND   8'h0C
`define RBIE_OFF_CONFIG  8'h10
`define RBIE_OFF_ESTATUS 8'h14
`define RBIE_OFF_EA      8'h18

`define RBIE_B_GIE     0
`define RBIE_B_U       1
`define RBIE_B_EXC     2
`define RBIE_B_NMI     3
`define RBIE_F_LVL     9:4
`define RBIE_F_CUR_RS  15:10
`define RBIE_F_PREV_RS 21:16
`define RBIE_B_RST_IE  23
`define RBIE_B_NEST    0

`define RBIE_STATUS_RST 32'h0080_0000
`define RBIE_GPR_BA     5'h1E
`define RBIE_INSN_BYTES 32'h0000_0004
`define RBIE_RESP_OKAY  2'h0
`define RBIE_RESP_SLV   2'h2

`endif

/* common/rbie_pkg.sv */
package rbie_pkg;
  typedef enum logic [0:0] {
    RBIE_ST_INVAL = 1'b0,
    RBIE_ST_RUN   = 1'b1
  } rbie_state_e;
  typedef logic [5:0] rbie_level_t;
  typedef logic [5:0] rbie_regset_t;
endpackage

/* design/rbie_exc_unit.sv */
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rbie_consts.svh"

module rbie_exc_unit #(
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000,
  parameter logic [31:0] BREAK_VECTOR = 32'h0000_0020,
  parameter logic [31:0] GEN_VECTOR   = 32'h0000_0040,
  parameter bit          USE_EXT_CTRL = 1'b1,
  parameter bit          HAS_MMU      = 1'b1,
  parameter bit          HAS_MPU      = 1'b0,
  parameter bit          HAS_SHADOW   = 1'b1,
  parameter int          NUM_IRQ      = 32
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output var  logic                 awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output var  logic                 wready,
  output var  logic [1:0]           bresp,
  output var  logic                 bvalid,
  input  wire logic                 bready,
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output var  logic                 arready,
  output var  logic [31:0]          rdata,
  output var  logic [1:0]           rresp,
  output var  logic                 rvalid,
  input  wire logic                 rready,
  input  wire logic                 insn_boundary,
  input  wire logic [31:0]          insn_pc,
  input  wire logic                 brk_insn,
  input  wire logic                 bret_insn,
  input  wire logic                 hw_break_req,
  input  wire logic [NUM_IRQ-1:0]   irq_request_inputs,
  input  wire logic                 ext_irq_req,
  input  wire logic [31:0]          handler_vector_addr,
  input  wire rbie_pkg::rbie_level_t  requested_level,
  input  wire rbie_pkg::rbie_regset_t requested_regset,
  input  wire logic                 requested_nonmaskable,
  input  wire logic                 gpr_we,
  input  wire logic [4:0]           gpr_waddr,
  input  wire logic [31:0]          gpr_wdata,
  input  wire logic [4:0]           gpr_raddr,
  output var  logic [31:0]          gpr_rdata,
  output var  logic                 redirect,
  output var  logic [31:0]          redirect_addr,
  output var  logic                 icache_inval,
  output var  logic [31:0]          icache_inval_addr,
  output var  logic                 irq_taken,
  output var  rbie_pkg::rbie_regset_t current_regset
);
  import rbie_pkg::*;

  rbie_state_e      st_ff;
  logic [31:0]      status_ff;
  logic [31:0]      nxt_status;
  logic [31:0]      bstatus_ff;
  logic [31:0]      nxt_bstatus;
  logic [31:0]      estatus_ff;
  logic [31:0]      nxt_estatus;
  logic [31:0]      ea_ff;
  logic [NUM_IRQ-1:0] ienable_ff;
  logic             auto_nest_flag_ff;
  logic [NUM_IRQ-1:0] irq_s1_ff;
  logic [NUM_IRQ-1:0] irq_s2_ff;
  logic [NUM_IRQ-1:0] irq_s3_ff;
  logic [NUM_IRQ-1:0] irq_stb_ff;
  logic [2:0]       brk_sync_ff;
  logic             brk_stb_ff;
  logic             brk_seen_ff;
  logic [31:0]      gpr_mem [0:31];
  logic             aw_got_ff;
  logic             w_got_ff;
  logic [7:0]       awaddr_ff;
  logic [31:0]      wdata_ff;
  logic [3:0]       wstrb_ff;
  logic             wr_fire;
  logic             nxt_aw_got;
  logic             nxt_w_got;
  logic             nxt_bvalid;
  logic             nxt_rvalid;
  logic             boundary;
  logic             hw_brk_pend;
  logic             irq_int;
  logic             irq_ext;
  logic             irq_any;
  logic             take_brk;
  logic             take_irq;
  logic             take_bret;
  logic [31:0]      ipending;
  logic [31:0]      wr_val;

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == `RBIE_OFF_STATUS) || (a == `RBIE_OFF_BSTATUS) ||
                 (a == `RBIE_OFF_IENABLE) || (a == `RBIE_OFF_IPEND) ||
                 (a == `RBIE_OFF_CONFIG) || (a == `RBIE_OFF_ESTATUS) ||
                 (a == `RBIE_OFF_EA);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // three-stage pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_s1_ff   <= '0;
      irq_s2_ff   <= '0;
      irq_s3_ff   <= '0;
      irq_stb_ff  <= '0;
      brk_sync_ff <= 3'h0;
      brk_stb_ff  <= 1'b0;
    end else begin
      irq_s1_ff   <= irq_request_inputs;
      irq_s2_ff   <= irq_s1_ff;
      irq_s3_ff   <= irq_s2_ff;
      irq_stb_ff  <= (irq_s2_ff & irq_s3_ff) | (irq_stb_ff & (irq_s2_ff | irq_s3_ff));
      brk_sync_ff <= {brk_sync_ff[1:0], hw_break_req};
      if (brk_sync_ff[1] == brk_sync_ff[2]) begin
        brk_stb_ff <= brk_sync_ff[1];
      end
    end
  end

  // a held debug request is taken once; it must drop before it can break again
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brk_seen_ff <= 1'b0;
    end else if (!brk_stb_ff) begin
      brk_seen_ff <= 1'b0;
    end else if (take_brk) begin
      brk_seen_ff <= 1'b1;
    end
  end

  assign ipending    = 32'(irq_stb_ff & ienable_ff);
  assign boundary    = insn_boundary && (st_ff == RBIE_ST_RUN);
  assign hw_brk_pend = brk_stb_ff && !brk_seen_ff;
  assign irq_int     = !USE_EXT_CTRL && status_ff[`RBIE_B_GIE] && (|ipending);
  assign irq_ext     = USE_EXT_CTRL && ext_irq_req &&
                       (requested_nonmaskable ||
                        (status_ff[`RBIE_B_GIE] &&
                         (requested_level > status_ff[`RBIE_F_LVL])));
  assign irq_any     = irq_int || irq_ext;
  // hardware break outranks interrupts, which outrank the instruction at the boundary
  assign take_brk    = boundary && (hw_brk_pend || (!irq_any && brk_insn));
  assign take_irq    = boundary && !hw_brk_pend && irq_any;
  assign take_bret   = boundary && !hw_brk_pend && !irq_any && !brk_insn && bret_insn;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= RBIE_ST_INVAL;
    end else begin
      st_ff <= RBIE_ST_RUN;
    end
  end

  always_comb begin
    wr_val      = merge(32'h0000_0000, wdata_ff, wstrb_ff);
    nxt_status  = status_ff;
    nxt_bstatus = bstatus_ff;
    nxt_estatus = estatus_ff;
    if (wr_fire && awaddr_ff == `RBIE_OFF_STATUS) begin
      nxt_status = merge(status_ff, wdata_ff, wstrb_ff);
    end
    if (wr_fire && awaddr_ff == `RBIE_OFF_BSTATUS) begin
      nxt_bstatus = merge(bstatus_ff, wdata_ff, wstrb_ff);
    end
    if (wr_fire && awaddr_ff == `RBIE_OFF_ESTATUS) begin
      nxt_estatus = merge(estatus_ff, wdata_ff, wstrb_ff);
    end
    // hardware entry wins over a software write in the same cycle
    if (take_brk) begin
      nxt_bstatus = status_ff;
      nxt_status = status_ff;
      nxt_status[`RBIE_B_GIE] = 1'b0;
      if (HAS_MMU || HAS_MPU) begin
        nxt_status[`RBIE_B_U] = 1'b0;
      end
      if (HAS_MMU) begin
        nxt_status[`RBIE_B_EXC] = 1'b1;
      end
      nxt_status[`RBIE_F_PREV_RS] = status_ff[`RBIE_F_CUR_RS];
      nxt_status[`RBIE_F_CUR_RS] = 6'h00;
    end else if (take_irq) begin
      nxt_estatus = status_ff;
      nxt_status = status_ff;
      if (!(USE_EXT_CTRL && auto_nest_flag_ff)) begin
        nxt_status[`RBIE_B_GIE] = 1'b0;
      end
      if (HAS_MMU || HAS_MPU) begin
        nxt_status[`RBIE_B_U] = 1'b0;
      end
      if (HAS_MMU) begin
        nxt_status[`RBIE_B_EXC] = 1'b1;
      end
      nxt_status[`RBIE_F_PREV_RS] = status_ff[`RBIE_F_CUR_RS];
      if (USE_EXT_CTRL) begin
        nxt_status[`RBIE_B_NMI] = requested_nonmaskable;
        if (!requested_nonmaskable) begin
          nxt_status[`RBIE_F_LVL] = requested_level;
        end
        if (HAS_SHADOW) begin
          nxt_status[`RBIE_F_CUR_RS] = requested_regset;
        end
      end
    end else if (take_bret) begin
      nxt_status = bstatus_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_ff  <= `RBIE_STATUS_RST;
      bstatus_ff <= 32'h0000_0000;
      estatus_ff <= 32'h0000_0000;
    end else begin
      status_ff  <= nxt_status;
      bstatus_ff <= nxt_bstatus;
      estatus_ff <= nxt_estatus;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ienable_ff        <= '0;
      auto_nest_flag_ff <= 1'b0;
      ea_ff             <= 32'h0000_0000;
    end else begin
      if (wr_fire && awaddr_ff == `RBIE_OFF_IENABLE) begin
        ienable_ff <= NUM_IRQ'(merge(32'(ienable_ff), wdata_ff, wstrb_ff));
      end
      if (wr_fire && awaddr_ff == `RBIE_OFF_CONFIG && wstrb_ff[0]) begin
        auto_nest_flag_ff <= wr_val[`RBIE_B_NEST];
      end
      if (take_irq) begin
        ea_ff <= insn_pc;
      end
    end
  end

  // normal register set; contents are undefined after reset by design
  always_ff @(posedge clk) begin
    if (take_brk) begin
      // a debug break stops before insn_pc, a break instruction resumes after it
      gpr_mem[`RBIE_GPR_BA] <= hw_brk_pend ? insn_pc : insn_pc + `RBIE_INSN_BYTES;
    end else if (gpr_we && gpr_waddr != 5'h00) begin
      gpr_mem[gpr_waddr] <= gpr_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpr_rdata <= 32'h0000_0000;
    end else if (gpr_raddr == 5'h00) begin
      gpr_rdata <= 32'h0000_0000;
    end else begin
      gpr_rdata <= gpr_mem[gpr_raddr];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      redirect          <= 1'b0;
      redirect_addr     <= 32'h0000_0000;
      icache_inval      <= 1'b0;
      icache_inval_addr <= 32'h0000_0000;
      irq_taken         <= 1'b0;
    end else begin
      redirect     <= 1'b0;
      icache_inval <= 1'b0;
      irq_taken    <= take_irq;
      if (st_ff == RBIE_ST_INVAL) begin
        // only the reset line is cleared so reset code is fetched uncached
        icache_inval      <= 1'b1;
        icache_inval_addr <= RESET_VECTOR;
        redirect          <= 1'b1;
        redirect_addr     <= RESET_VECTOR;
      end else if (take_brk) begin
        redirect      <= 1'b1;
        redirect_addr <= BREAK_VECTOR;
      end else if (take_irq) begin
        redirect      <= 1'b1;
        redirect_addr <= USE_EXT_CTRL ? handler_vector_addr : GEN_VECTOR;
      end else if (take_bret) begin
        redirect      <= 1'b1;
        redirect_addr <= gpr_mem[`RBIE_GPR_BA];
      end
    end
  end

  assign current_regset = status_ff[`RBIE_F_CUR_RS];

  // write channel: address and data are taken in either order
  assign wr_fire    = aw_got_ff && w_got_ff;
  assign nxt_aw_got = aw_got_ff ? !wr_fire : (awvalid && awready);
  assign nxt_w_got  = w_got_ff ? !wr_fire : (wvalid && wready);
  assign nxt_bvalid = wr_fire || (bvalid && !bready);
  assign nxt_rvalid = (arvalid && arready) || (rvalid && !rready);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RBIE_RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff  <= nxt_w_got;
      awready   <= !nxt_aw_got && !nxt_bvalid;
      wready    <= !nxt_w_got && !nxt_bvalid;
      bvalid    <= nxt_bvalid;
      if (awvalid && awready) begin
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_fire) begin
        bresp <= reg_mapped(awaddr_ff) ? `RBIE_RESP_OKAY : `RBIE_RESP_SLV;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RBIE_RESP_OKAY;
    end else begin
      arready <= !nxt_rvalid;
      rvalid  <= nxt_rvalid;
      if (arvalid && arready) begin
        rresp <= reg_mapped(araddr) ? `RBIE_RESP_OKAY : `RBIE_RESP_SLV;
        unique case (araddr)
          `RBIE_OFF_STATUS:  rdata <= status_ff;
          `RBIE_OFF_BSTATUS: rdata <= bstatus_ff;
          `RBIE_OFF_IENABLE: rdata <= 32'(ienable_ff);
          `RBIE_OFF_IPEND:   rdata <= ipending;
          `RBIE_OFF_CONFIG:  rdata <= {31'h0000_0000, auto_nest_flag_ff};
          `RBIE_OFF_ESTATUS: rdata <= estatus_ff;
          `RBIE_OFF_EA:      rdata <= ea_ff;
          default:           rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_brk_state;
    !status_ff[`RBIE_B_GIE] && status_ff[`RBIE_F_CUR_RS] == 6'h00;
  endsequence

  a_reset_status: assert property (
    st_ff == RBIE_ST_INVAL |-> status_ff == `RBIE_STATUS_RST)
    else $error("status not at reset value");
  a_reset_inval: assert property (
    $rose(st_ff == RBIE_ST_RUN) |-> icache_inval && icache_inval_addr == RESET_VECTOR
                                    && redirect && redirect_addr == RESET_VECTOR)
    else $error("reset line not invalidated before fetch");
  a_zero_reads: assert property (
    gpr_raddr == 5'h00 |=> gpr_rdata == 32'h0000_0000)
    else $error("register zero read nonzero");
  a_hwbrk_taken: assert property (
    boundary && hw_brk_pend |-> take_brk ##1 !hw_brk_pend)
    else $error("debug break not taken at boundary");
  a_brk_entry: assert property (
    take_brk |=> bstatus_ff == $past(status_ff) ##0 s_brk_state)
    else $error("break entry status wrong");
  a_brk_regset: assert property (
    take_brk |=> status_ff[`RBIE_F_PREV_RS] == $past(status_ff[`RBIE_F_CUR_RS]))
    else $error("previous regset not saved");
  a_brk_return: assert property (
    take_brk && brk_insn && !hw_brk_pend |=>
      gpr_mem[`RBIE_GPR_BA] == $past(insn_pc) + `RBIE_INSN_BYTES)
    else $error("break return address wrong");
  a_brk_vector: assert property (
    take_brk |=> redirect && redirect_addr == BREAK_VECTOR)
    else $error("break vector not taken");
  a_bret_restore: assert property (
    take_bret |=> status_ff == $past(bstatus_ff) && redirect
                  && redirect_addr == $past(gpr_mem[`RBIE_GPR_BA]))
    else $error("break return not restored");
  a_ext_level: assert property (
    take_irq && USE_EXT_CTRL && !requested_nonmaskable |->
      requested_level > status_ff[`RBIE_F_LVL])
    else $error("maskable irq at too low a level");
  a_nmi_taken: assert property (
    boundary && !hw_brk_pend && USE_EXT_CTRL && ext_irq_req && requested_nonmaskable |-> take_irq)
    else $error("nonmaskable irq refused");
  a_int_gie: assert property (
    take_irq && !USE_EXT_CTRL |=> !status_ff[`RBIE_B_GIE] && redirect_addr == GEN_VECTOR)
    else $error("internal irq left enable set");

endmodule
`default_nettype wire

/* sim/rbie_far_end.sv */
`timescale 1ns/10ps
`default_nettype none

module rbie_far_end (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   go,
  input  wire logic [31:0]            ha,
  input  wire rbie_pkg::rbie_level_t  lvl,
  input  wire rbie_pkg::rbie_regset_t rs,
  input  wire logic                   nm,
  input  wire logic                   irq_taken,
  output var  logic                   ext_irq_req,
  output var  logic [31:0]            handler_vector_addr,
  output var  rbie_pkg::rbie_level_t  requested_level,
  output var  rbie_pkg::rbie_regset_t requested_regset,
  output var  logic                   requested_nonmaskable
);
  import rbie_pkg::*;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_irq_req <= 1'b0;
      handler_vector_addr <= 32'h0;
      requested_level <= 6'h0;
      requested_regset <= 6'h0;
      requested_nonmaskable <= 1'b0;
    end else if (go) begin
      // all four fields travel with the request
      ext_irq_req <= 1'b1;
      handler_vector_addr <= ha;
      requested_level <= lvl;
      requested_regset <= rs;
      requested_nonmaskable <= nm;
    end else if (irq_taken) begin
      // released fields must not keep looking valid to the core
      ext_irq_req <= 1'b0;
      requested_nonmaskable <= ~requested_nonmaskable;
      handler_vector_addr <= ~handler_vector_addr;
      requested_level <= ~requested_level;
      requested_regset <= ~requested_regset;
    end
  end
endmodule

`default_nettype wire

/* sim/rbie_exc_unit_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rbie_consts.svh"

module rbie_exc_unit_tb;
  import rbie_pkg::*;
  logic         clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic         rvalid, rready, insn_boundary, brk_insn, bret_insn, hw_break_req, ext_irq_req;
  logic         requested_nonmaskable, gpr_we, redirect, icache_inval, irq_taken, go, nm;
  logic         rd, tk, tk2, irq_taken2, seen, take, gie, nest;
  logic [1:0]   bresp, rresp, rr, wr;
  logic [31:0]  ra2, redirect_addr2;
  logic [3:0]   wstrb;
  logic [4:0]   gpr_waddr, gpr_raddr, ga;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, insn_pc, irq_request_inputs, handler_vector_addr, gpr_wdata;
  logic [31:0]  gpr_rdata, redirect_addr, icache_inval_addr, ha, ra, d, s, e, pc, v, m, seed;
  rbie_level_t  requested_level, lvl, lv;
  rbie_regset_t requested_regset, current_regset, rs;
  int           num_errors, total_checks;

  rbie_exc_unit rbie_exc_unit_inst (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .insn_boundary, .insn_pc, .brk_insn, .bret_insn, .hw_break_req,
    .irq_request_inputs, .ext_irq_req, .handler_vector_addr, .requested_level, .requested_regset,
    .requested_nonmaskable, .gpr_we, .gpr_waddr, .gpr_wdata, .gpr_raddr, .gpr_rdata, .redirect,
    .redirect_addr, .icache_inval, .icache_inval_addr, .irq_taken, .current_regset);

  // internal-controller build on the same stimulus, watched at its redirect address and irq_taken only
  rbie_exc_unit #(.USE_EXT_CTRL(1'b0)) rbie_exc_unit_int_inst (.clk, .nrst, .awaddr, .awvalid,
    .awready(), .wdata, .wstrb, .wvalid, .wready(), .bresp(), .bvalid(), .bready, .araddr,
    .arvalid, .arready(), .rdata(), .rresp(), .rvalid(), .rready, .insn_boundary, .insn_pc,
    .brk_insn, .bret_insn, .hw_break_req, .irq_request_inputs, .ext_irq_req,
    .handler_vector_addr, .requested_level, .requested_regset, .requested_nonmaskable, .gpr_we,
    .gpr_waddr, .gpr_wdata, .gpr_raddr, .gpr_rdata(), .redirect(),
    .redirect_addr(redirect_addr2), .icache_inval(), .icache_inval_addr(),
    .irq_taken(irq_taken2), .current_regset());

  rbie_far_end rbie_far_end_inst (.clk, .nrst, .go, .ha, .lvl, .rs, .nm, .irq_taken, .ext_irq_req,
    .handler_vector_addr, .requested_level, .requested_regset, .requested_nonmaskable);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_brk(input logic [31:0] o);
    logic [31:0] x;
    x = o;
    x[`RBIE_B_GIE] = 1'b0;
    x[`RBIE_B_U] = 1'b0;
    x[`RBIE_B_EXC] = 1'b1;
    x[`RBIE_F_PREV_RS] = o[`RBIE_F_CUR_RS];
    x[`RBIE_F_CUR_RS] = 6'h0;
    return x;
  endfunction

  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nme, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nme, ex, got);
    end
  endtask

  // handshakes are judged at the falling edge: readies only move on rising edges
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] x);
    logic ah, wh, bh;
    @(posedge clk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      wr = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] r);
    logic ah, rh;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ah = arvalid & arready;
      rh = rvalid;
      x = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
  endtask

  task automatic bnd(input logic [31:0] p, input logic b, input logic r);
    @(posedge clk);
    insn_boundary <= 1'b1;
    insn_pc <= p;
    brk_insn <= b;
    bret_insn <= r;
    @(posedge clk);
    insn_boundary <= 1'b0;
    brk_insn <= 1'b0;
    bret_insn <= 1'b0;
    #1;
    rd = redirect;
    ra = redirect_addr;
    tk = irq_taken;
    ra2 = redirect_addr2;
    tk2 = irq_taken2;
    @(posedge clk);
  endtask

  task automatic gput(input logic [4:0] a, input logic [31:0] x);
    @(posedge clk);
    gpr_we <= 1'b1;
    gpr_waddr <= a;
    gpr_wdata <= x;
    @(posedge clk);
    gpr_we <= 1'b0;
  endtask

  task automatic gget(input logic [4:0] a, output logic [31:0] x);
    @(posedge clk);
    gpr_raddr <= a;
    @(posedge clk);
    #1;
    x = gpr_rdata;
  endtask

  initial begin
    #(30000 * 25);
    num_errors++;
    finish_test();
  end

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, insn_boundary, brk_insn, bret_insn} = '0;
    {hw_break_req, gpr_we, go, nm, awaddr, araddr, wdata, insn_pc, gpr_wdata} = '0;
    {irq_request_inputs, gpr_waddr, gpr_raddr, ha, lvl, rs} = '0;
    wstrb = 4'hF;
    seed = 32'hD22D;
    num_errors = 0;
    total_checks = 0;
    seen = 1'b0;
    ra = 32'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (icache_inval && redirect) begin
        seen = 1'b1;
        ra = icache_inval_addr;
      end
    end
    chk("reset_fetch", 32'h1, {31'h0, seen});
    chk("reset_inval_addr", 32'h0, ra);
    axi_rd(`RBIE_OFF_STATUS, d, rr);
    chk("status_reset", 32'h0080_0000, d);
    axi_rd(8'h3C, d, rr);
    chk("unmapped_resp", 32'h2, {30'h0, rr});
    axi_wr(8'h3C, 32'h0000_0000);
    chk("unmapped_wresp", 32'h2, {30'h0, wr});
    for (int i = 0; i < 4; i++) begin
      ga = (i == 0) ? 5'h0 : 5'(xs() % 29) + 5'h1;
      v = xs();
      gput(ga, v);
      gget(ga, d);
      chk("gpr_read", (ga == 5'h0) ? 32'h0 : v, d);
    end
    for (int i = 0; i < 3; i++) begin
      s = xs() & 32'h00BF_FFF7;
      pc = xs() & 32'hFFFF_FFFC;
      axi_wr(`RBIE_OFF_STATUS, s);
      bnd(pc, 1'b1, 1'b0);
      chk("brk_redirect", 32'h1, {31'h0, rd});
      chk("brk_vector", 32'h20, ra);
      chk("brk_regset", 32'h0, {26'h0, current_regset});
      axi_rd(`RBIE_OFF_BSTATUS, d, rr);
      chk("bstatus", s, d);
      axi_rd(`RBIE_OFF_STATUS, d, rr);
      chk("brk_status", exp_brk(s), d);
      gget(5'h1E, d);
      chk("brk_return_reg", pc + 32'h4, d);
      bnd(xs() & 32'hFFFF_FFFC, 1'b0, 1'b1);
      chk("bret_target", pc + 32'h4, ra);
      axi_rd(`RBIE_OFF_STATUS, d, rr);
      chk("bret_status", s, d);
    end
    // the debug request crosses a synchroniser, so give it time before the boundary
    hw_break_req <= 1'b1;
    repeat (6) @(posedge clk);
    pc = xs() & 32'hFFFF_FFFC;
    bnd(pc, 1'b0, 1'b0);
    chk("dbg_vector", 32'h20, ra);
    gget(5'h1E, d);
    chk("dbg_return_reg", pc, d);
    hw_break_req <= 1'b0;
    repeat (6) @(posedge clk);
    // a refused request stays pending for good, so that case runs last
    for (int k = 0; k < 4; k++) begin
      lv = 6'(xs() % 32'd31) + 6'h1;
      gie = (k != 2);
      nest = (k == 1);
      take = (k != 3);
      e = 32'h0080_0000 | {22'h0, lv, 3'h0, gie};
      axi_wr(`RBIE_OFF_CONFIG, {31'h0, nest});
      axi_wr(`RBIE_OFF_STATUS, e);
      @(posedge clk);
      go <= 1'b1;
      ha <= xs() & 32'hFFFF_FFFC;
      lvl <= (k == 3) ? lv : ((k == 2) ? lv - 6'h1 : lv + 6'h1);
      rs <= 6'(xs());
      nm <= (k == 2);
      @(posedge clk);
      go <= 1'b0;
      pc = xs() & 32'hFFFF_FFFC;
      bnd(pc, 1'b0, 1'b0);
      chk("irq_taken", {31'h0, take}, {31'h0, tk});
      if (take) begin
        chk("irq_handler", ha, ra);
        chk("irq_regset", {26'h0, rs}, {26'h0, current_regset});
        axi_rd(`RBIE_OFF_STATUS, d, rr);
        chk("irq_gie", {31'h0, nest & gie}, {31'h0, d[`RBIE_B_GIE]});
        axi_rd(`RBIE_OFF_ESTATUS, d, rr);
        chk("irq_saved_status", e, d);
        axi_rd(`RBIE_OFF_EA, d, rr);
        chk("irq_saved_pc", pc, d);
      end
    end
    m = xs() | 32'h0000_0001;
    axi_wr(`RBIE_OFF_IENABLE, m);
    irq_request_inputs <= xs() | 32'h0000_0001; // held for the rest of the test
    repeat (6) @(posedge clk);
    axi_rd(`RBIE_OFF_IPEND, d, rr);
    chk("ipending", irq_request_inputs & m, d);
    bnd(pc, 1'b0, 1'b0);
    chk("int_irq_taken", 32'h1, {31'h0, tk2});
    chk("int_irq_vector", 32'h40, ra2);
    bnd(pc, 1'b0, 1'b0);
    chk("int_irq_masked", 32'h0, {31'h0, tk2});
    finish_test();
  end
endmodule

`default_nettype wire
